// ---- logic/psm_pkg.sv ----
// Shared constants and types for the power and system management block
package psm_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // Least button pulse, in microseconds
  localparam int unsigned MIN_PULSE_US = 16000;
  localparam int unsigned MIN_PULSE_CYC =
    (MIN_PULSE_US * (CLK_HZ / 1000000));
  // Carrier reset stretch after all sources clear, in microseconds
  localparam int unsigned RST_HOLD_US = 1000;
  localparam int unsigned RST_HOLD_CYC =
    (RST_HOLD_US * (CLK_HZ / 1000000));
  localparam int unsigned CNT_W = 20;
  localparam int unsigned SYNC_W = 12;

  // Synchronised input positions
  localparam int unsigned IX_POWER_BUTTON_N = 0;
  localparam int unsigned IX_RSTBTN = 1;
  localparam int unsigned IX_COVER = 2;
  localparam int unsigned IX_STBY = 3;
  localparam int unsigned IX_SUPOK = 4;
  localparam int unsigned IX_V12OK = 5;
  localparam int unsigned IX_PWAKE = 6;
  localparam int unsigned IX_GWAKE = 7;
  localparam int unsigned IX_BATLO = 8;
  localparam int unsigned IX_OVTMP = 9;
  localparam int unsigned IX_ALERT = 10;
  localparam int unsigned IX_TRIP = 11;

  typedef enum logic [3:0] {
    PSM_OFF = 4'h1,
    PSM_ON = 4'h2,
    PSM_SUSPEND = 4'h4,
    PSM_RAM = 4'h8
  } psm_state_t;

  typedef struct packed {
    logic powerPress;
    logic resetPress;
    logic coverPress;
    logic standbyPress;
    logic pcieWake;
    logic generalWake;
    logic batteryLow;
    logic overTemp;
    logic alert;
  } psm_events_t;
endpackage

// ---- logic/psm_sync.sv ----
// Two-flop input synchroniser
`timescale 1ns/1ps
module psm_sync import psm_pkg::*; #(
  parameter int unsigned W = SYNC_W,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= INIT;
      syncOut <= INIT;
    end else if (ce) begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule // psm_sync

// ---- logic/psm_pulse_qual.sv ----
// Pulse-width qualifier for one active-low button
`timescale 1ns/1ps
module psm_pulse_qual import psm_pkg::*; #(
  parameter int unsigned MIN_CYC = MIN_PULSE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic levelN,
  output logic press
);
  logic [CNT_W-1:0] cnt_q;
  logic fired_q;

  // One pulse per low period, once it has lasted MIN_CYC cycles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
      press <= 1'b0;
    end else if (ce) begin
      press <= 1'b0;
      if (levelN) begin
        cnt_q <= '0;
        fired_q <= 1'b0;
      end else if (!fired_q) begin
        if (cnt_q >= CNT_W'(MIN_CYC - 1)) begin
          press <= 1'b1;
          fired_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule // psm_pulse_qual

// ---- logic/psm_power_mgmt.sv ----
// Power and system management sequencer top
// How it works
// - Power button falling edge wakes the system from soft off.
// - Buttons are qualified by a least pulse width of 16 ms.
// - Reset button acts on its falling edge only.
// - A held reset button does not keep the carrier in reset.
// - Reset button, supply fault or 12 V fault reset the carrier.
// - Watchdog timeout or software request also reset the carrier.
// - Suspend pending is asserted before a suspend begins.
// - Sleep-RAM indication is low while in suspend to RAM.
// - Suspend-to-disk is unsupported; its output stays high.
// - Soft-off indication is low while in soft off.
// - PCIe and general wake inputs wake the system.
// - Battery low input is reported as a power event.
// - Overtemp input is taken as an over-temperature report.
// - CPU thermal halt goes low once thermal shutdown is entered.
// - Bus alert raises a management interrupt or wakes, per config.
// - Standby button and cover switch presses are reported.
`timescale 1ns/1ps
module psm_power_mgmt import psm_pkg::*; #(
  parameter int unsigned PULSE_CYC = MIN_PULSE_CYC,
  parameter int unsigned HOLD_CYC = RST_HOLD_CYC,
  parameter int unsigned SUSPEND_CYC = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic power_button_n,
  input wire logic reset_button_n,
  input wire logic cover_switch_n,
  input wire logic standby_button_n,
  input wire logic supply_good,
  input wire logic main_12v_ok,
  input wire logic pcie_wake_n,
  input wire logic general_wake_n,
  input wire logic battery_low_n,
  input wire logic overtemp_in_n,
  input wire logic mgmt_bus_alert_n,
  input wire logic cpu_thermal_trip,
  input wire logic watchdog_timeout,
  input wire logic soft_reset_req,
  input wire logic suspend_req,
  input wire logic soft_off_req,
  input wire logic alert_wake_en,
  output logic carrier_reset_out_n,
  output logic suspend_pending_n,
  output logic sleep_ram_state_n,
  output logic sleep_disk_state_n,
  output logic soft_off_state_n,
  output logic cpu_thermal_halt_n,
  output logic system_mgmt_interrupt_n,
  output psm_events_t events,
  output psm_state_t powerState
);
  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] syncIn;
  logic powerPress;
  logic resetPress;
  logic coverPress;
  logic standbyPress;
  logic pwake_q;
  logic gwake_q;
  logic alert_q;
  logic wakeEvent;
  logic resetSrc;
  logic [CNT_W-1:0] hold_q;
  logic [CNT_W-1:0] susp_q;
  psm_state_t state_q;
  psm_state_t state_d;

  always_comb begin
    rawIn = '0;
    rawIn[IX_POWER_BUTTON_N] = power_button_n;
    rawIn[IX_RSTBTN] = reset_button_n;
    rawIn[IX_COVER] = cover_switch_n;
    rawIn[IX_STBY] = standby_button_n;
    rawIn[IX_SUPOK] = supply_good;
    rawIn[IX_V12OK] = main_12v_ok;
    rawIn[IX_PWAKE] = pcie_wake_n;
    rawIn[IX_GWAKE] = general_wake_n;
    rawIn[IX_BATLO] = battery_low_n;
    rawIn[IX_OVTMP] = overtemp_in_n;
    rawIn[IX_ALERT] = mgmt_bus_alert_n;
    rawIn[IX_TRIP] = cpu_thermal_trip;
  end

  // Idle levels at reset: buttons released, power good, no trip
  psm_sync #(
    .W(SYNC_W),
    .INIT(SYNC_W'(~(SYNC_W'(1) << IX_TRIP)))
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  // Qualified presses fire once per low period, so a held
  // reset button yields one event only
  psm_pulse_qual #(.MIN_CYC(PULSE_CYC)) u_qual_pwr (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .levelN(syncIn[IX_POWER_BUTTON_N]), .press(powerPress)
  );
  psm_pulse_qual #(.MIN_CYC(PULSE_CYC)) u_qual_rst (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .levelN(syncIn[IX_RSTBTN]), .press(resetPress)
  );
  psm_pulse_qual #(.MIN_CYC(PULSE_CYC)) u_qual_cov (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .levelN(syncIn[IX_COVER]), .press(coverPress)
  );
  psm_pulse_qual #(.MIN_CYC(PULSE_CYC)) u_qual_stb (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .levelN(syncIn[IX_STBY]), .press(standbyPress)
  );

  // Falling-edge detect on wake and alert lines
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwake_q <= 1'b1;
      gwake_q <= 1'b1;
      alert_q <= 1'b1;
    end else if (ce) begin
      pwake_q <= syncIn[IX_PWAKE];
      gwake_q <= syncIn[IX_GWAKE];
      alert_q <= syncIn[IX_ALERT];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      events <= '0;
    end else if (ce) begin
      events.powerPress <= powerPress;
      events.resetPress <= resetPress;
      events.coverPress <= coverPress;
      events.standbyPress <= standbyPress;
      events.pcieWake <= pwake_q & ~syncIn[IX_PWAKE];
      events.generalWake <= gwake_q & ~syncIn[IX_GWAKE];
      events.batteryLow <= ~syncIn[IX_BATLO];
      events.overTemp <= ~syncIn[IX_OVTMP];
      events.alert <= alert_q & ~syncIn[IX_ALERT];
    end
  end

  // Management interrupt: low for one cycle per alert edge while alert_wake_en is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      system_mgmt_interrupt_n <= 1'b1;
    end else if (ce) begin
      system_mgmt_interrupt_n <=
        ~(alert_q & ~syncIn[IX_ALERT] & ~alert_wake_en);
    end
  end

  assign wakeEvent = powerPress
    | (pwake_q & ~syncIn[IX_PWAKE])
    | (gwake_q & ~syncIn[IX_GWAKE])
    | (alert_q & ~syncIn[IX_ALERT] & alert_wake_en)
    | standbyPress;

  // Sleep state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSM_OFF: begin
        if (wakeEvent) begin
          state_d = PSM_ON;
        end
      end
      PSM_ON: begin
        if (soft_off_req) begin
          state_d = PSM_OFF;
        end else if (suspend_req || standbyPress) begin
          state_d = PSM_SUSPEND;
        end
      end
      PSM_SUSPEND: begin
        if (susp_q >= CNT_W'(SUSPEND_CYC - 1)) begin
          state_d = PSM_RAM;
        end
      end
      PSM_RAM: begin
        if (wakeEvent) begin
          state_d = PSM_ON;
        end
      end
      default: state_d = PSM_OFF;
    endcase
  end

  assign powerState = state_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= PSM_OFF;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Pending notice lasts SUSPEND_CYC cycles before the RAM state
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      susp_q <= '0;
    end else if (ce) begin
      if (state_q == PSM_SUSPEND) begin
        susp_q <= susp_q + 1'b1;
      end else begin
        susp_q <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      suspend_pending_n <= 1'b1;
      sleep_ram_state_n <= 1'b1;
      sleep_disk_state_n <= 1'b1;
      soft_off_state_n <= 1'b0;
      cpu_thermal_halt_n <= 1'b1;
    end else if (ce) begin
      suspend_pending_n <= ~(state_d == PSM_SUSPEND);
      sleep_ram_state_n <= ~(state_d == PSM_RAM);
      sleep_disk_state_n <= 1'b1;
      soft_off_state_n <= ~(state_d == PSM_OFF);
      // Latched until reset; a tripped CPU does not recover alone
      if (syncIn[IX_TRIP]) begin
        cpu_thermal_halt_n <= 1'b0;
      end
    end
  end

  // Supply good low counts as a fault
  assign resetSrc = resetPress
    | ~syncIn[IX_SUPOK]
    | ~syncIn[IX_V12OK]
    | watchdog_timeout | soft_reset_req;

  // Stretch counter reloads on every source cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_q <= CNT_W'(HOLD_CYC);
      carrier_reset_out_n <= 1'b0;
    end else if (ce) begin
      if (resetSrc) begin
        hold_q <= CNT_W'(HOLD_CYC);
        carrier_reset_out_n <= 1'b0;
      end else if (hold_q != '0) begin
        hold_q <= hold_q - 1'b1;
        carrier_reset_out_n <= 1'b0;
      end else begin
        carrier_reset_out_n <= 1'b1;
      end
    end
  end
endmodule // psm_power_mgmt

// ---- test/psm_power_mgmt_props.sv ----
// Checker for the power and system management block
`timescale 1ns/1ps
module psm_power_mgmt_props import psm_pkg::*; #(
  parameter int unsigned HOLD_CYC = RST_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_good,
  input wire logic main_12v_ok,
  input wire logic watchdog_timeout,
  input wire logic soft_reset_req,
  input wire logic cpu_thermal_trip,
  input wire logic carrier_reset_out_n,
  input wire logic suspend_pending_n,
  input wire logic sleep_ram_state_n,
  input wire logic sleep_disk_state_n,
  input wire logic soft_off_state_n,
  input wire logic cpu_thermal_halt_n,
  input wire psm_events_t events
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [CNT_W-1:0] lowCnt_q;
  // Length of the current low run since reset release
  always_ff @(posedge ref_clk) begin
    if (rst || carrier_reset_out_n)
      lowCnt_q <= '0;
    else
      lowCnt_q <= lowCnt_q + 1'b1;
  end
  a_disk_never_low: assert property (sleep_disk_state_n)
    else $error("disk sleep output went low");
  a_fault_resets: assert property (!(supply_good && main_12v_ok) |-> ##[1:4] !carrier_reset_out_n)
    else $error("supply fault left carrier reset high");
  a_request_resets: assert property ((watchdog_timeout || soft_reset_req) |-> ##[1:2] !carrier_reset_out_n)
    else $error("reset request left carrier reset high");
  a_reset_stretch: assert property ($rose(carrier_reset_out_n) |-> lowCnt_q >= HOLD_CYC)
    else $error("carrier reset pulse too short");
  a_halt_sticky: assert property (!cpu_thermal_halt_n |=> !cpu_thermal_halt_n)
    else $error("thermal halt released");
  a_trip_halts: assert property (cpu_thermal_trip |-> ##[1:4] !cpu_thermal_halt_n)
    else $error("thermal trip not reported");
  a_suspend_first: assert property ($fell(sleep_ram_state_n) |-> $past(suspend_pending_n) == 1'b0)
    else $error("sleep entered without notice");
  a_press_wakes: assert property ($rose(events.powerPress) |-> ##[0:2] soft_off_state_n)
    else $error("power press left soft off");
  a_reset_once: assert property (events.resetPress |=> !events.resetPress)
    else $error("reset press repeated");
  cover property ($rose(carrier_reset_out_n));
  cover property ($fell(sleep_ram_state_n));
  cover property ($fell(cpu_thermal_halt_n));
endmodule // psm_power_mgmt_props

bind psm_power_mgmt psm_power_mgmt_props #(.HOLD_CYC(HOLD_CYC)) u_props (.*);

// ---- test/psm_carrier.sv ----
// Carrier board model: buttons and supply monitors
`timescale 1ns/1ps
module psm_carrier (
  input wire logic ref_clk,
  output logic [3:0] btnN,
  output logic supplyOk,
  output logic v12Ok
);
  // Released buttons rest at the pull-up level
  initial begin
    btnN = 4'hF;
    supplyOk = 1'b1;
    v12Ok = 1'b1;
  end
  // Press button i for n clocks; short n only to test refusal
  task automatic press(input int i, input int n);
    @(posedge ref_clk);
    btnN[i] <= 1'b0;
    repeat (n) @(posedge ref_clk);
    btnN[i] <= 1'b1;
  endtask
  task automatic power(input logic ok, input logic v12);
    @(posedge ref_clk);
    supplyOk <= ok;
    v12Ok <= v12;
  endtask
endmodule // psm_carrier

// ---- test/psm_power_mgmt_tb.sv ----
// Self-checking bench for the power and system management block
`timescale 1ns/1ps
module psm_power_mgmt_tb import psm_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic pWakeN = 1'b1, gWakeN = 1'b1, batLowN = 1'b1, hotN = 1'b1;
  logic alertN = 1'b1, trip = 1'b0, wdog = 1'b0, swRst = 1'b0;
  logic susReq = 1'b0, offReq = 1'b0, alertWake = 1'b0;
  logic crstN, pendN, ramN, diskN, offN, haltN, irqN, capIrq;
  wire logic [3:0] btnN;
  wire logic supOk, v12Ok;
  psm_events_t ev, capE;
  int nFail = 0, compares = 0;
  wire logic [4:0] o = {haltN, offN, ramN, pendN, crstN};
  always #20 ref_clk = ~ref_clk;
  psm_carrier u_car (.ref_clk(ref_clk), .btnN(btnN), .supplyOk(supOk),
    .v12Ok(v12Ok));
  psm_power_mgmt #(.PULSE_CYC(8), .HOLD_CYC(4)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1),
    .power_button_n(btnN[0]), .reset_button_n(btnN[1]),
    .cover_switch_n(btnN[2]), .standby_button_n(btnN[3]),
    .supply_good(supOk), .main_12v_ok(v12Ok), .pcie_wake_n(pWakeN),
    .general_wake_n(gWakeN), .battery_low_n(batLowN),
    .overtemp_in_n(hotN), .mgmt_bus_alert_n(alertN),
    .cpu_thermal_trip(trip), .watchdog_timeout(wdog),
    .soft_reset_req(swRst), .suspend_req(susReq), .soft_off_req(offReq),
    .alert_wake_en(alertWake), .carrier_reset_out_n(crstN),
    .suspend_pending_n(pendN), .sleep_ram_state_n(ramN),
    .sleep_disk_state_n(diskN), .soft_off_state_n(offN),
    .cpu_thermal_halt_n(haltN), .system_mgmt_interrupt_n(irqN),
    .events(ev), .powerState());
  // One-cycle pulses are caught here so waits cannot miss them
  always @(posedge ref_clk) begin
    capE = capE | ev;
    capIrq = capIrq | !irqN;
  end
  task automatic chk(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic waitO(input int i, input logic v, input int n);
    repeat (n) begin
      @(negedge ref_clk);
      if (o[i] === v)
        break;
    end
    chk(o[i], v);
  endtask
  task automatic clr;
    @(negedge ref_clk);
    capE = '0;
    capIrq = 1'b0;
  endtask
  task automatic t_boot;
    @(negedge ref_clk);
    chk(crstN, 1'b0);
    chk(offN, 1'b0);
    chk(diskN, 1'b1);
    waitO(0, 1'b1, 20);
  endtask
  task automatic t_power;
    u_car.press(0, 4);
    repeat (12) @(negedge ref_clk);
    chk(offN, 1'b0);
    u_car.press(0, 16);
    waitO(3, 1'b1, 30);
  endtask
  task automatic t_suspend;
    clr;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      if (i == 0) begin
        susReq <= 1'b1;
        @(posedge ref_clk);
        susReq <= 1'b0;
      end else
        u_car.press(3, 16);
      waitO(1, 1'b0, 20);
      waitO(2, 1'b0, 40);
      chk(pendN, 1'b1);
      @(posedge ref_clk);
      pWakeN <= i[0];
      gWakeN <= !i[0];
      repeat (4) @(posedge ref_clk);
      pWakeN <= 1'b1;
      gWakeN <= 1'b1;
      waitO(2, 1'b1, 10);
    end
    chk(capE.standbyPress, 1'b1);
    chk(capE.pcieWake & capE.generalWake, 1'b1);
  endtask
  task automatic t_misc;
    clr;
    u_car.press(2, 16);
    waitO(3, 1'b1, 4);
    chk(capE.coverPress, 1'b1);
    @(posedge ref_clk);
    batLowN <= 1'b0;
    hotN <= 1'b0;
    alertN <= 1'b0;
    // Two sync flops plus the event register
    repeat (5) @(negedge ref_clk);
    waitO(3, 1'b1, 6);
    chk(ev.batteryLow, 1'b1);
    chk(ev.overTemp, 1'b1);
    chk(capIrq, 1'b1);
    @(posedge ref_clk);
    {batLowN, hotN, alertN, offReq} <= 4'hF;
    @(posedge ref_clk);
    offReq <= 1'b0;
    alertWake <= 1'b1;
    waitO(3, 1'b0, 6);
    @(posedge ref_clk);
    alertN <= 1'b0;
    waitO(3, 1'b1, 10);
    @(posedge ref_clk);
    alertN <= 1'b1;
  endtask
  task automatic t_resets;
    clr;
    fork
      u_car.press(1, 60);
    join_none
    waitO(0, 1'b0, 30);
    waitO(0, 1'b1, 30);
    chk(capE.resetPress, 1'b1);
    repeat (40) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      if (i < 2)
        u_car.power(i[0], !i[0]);
      else begin
        @(posedge ref_clk);
        {wdog, swRst} <= i[0] ? 2'b10 : 2'b01;
        @(posedge ref_clk);
        {wdog, swRst} <= 2'b00;
      end
      waitO(0, 1'b0, 6);
      u_car.power(1'b1, 1'b1);
      waitO(0, 1'b1, 20);
    end
  endtask
  task automatic t_thermal;
    @(posedge ref_clk);
    trip <= 1'b1;
    waitO(4, 1'b0, 6);
    @(posedge ref_clk);
    trip <= 1'b0;
    repeat (6) @(posedge ref_clk);
    waitO(4, 1'b0, 1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    capE = '0;
    capIrq = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_boot;
    t_power;
    t_suspend;
    t_misc;
    t_resets;
    t_thermal;
    results;
  end
  // Whole run needs well under this many cycles
  initial begin
    repeat (3000) @(posedge ref_clk);
    nFail++;
    results;
  end
endmodule // psm_power_mgmt_tb
